/* File: hdl/bss_params.svh */
/*
 * Constants of the buck supply supervisor: register map, field positions,
 * reset values and timing figures.
 * Assumes it is included by bare name, before the package and the module.
 */
`ifndef BSS_PARAMS_SVH
`define BSS_PARAMS_SVH

// ==========================================================
// Clock and timing
`define BSS_CLK_NS 5
`define BSS_NS_PER_US 1000
`define BSS_NS_PER_MS 1000000
`define BSS_F500_KHZ 500
`define BSS_F1M_KHZ 1000
`define BSS_PCT_FULL 100
`define BSS_DUTY_MAX_PCT 90
`define BSS_DEAD_CYC 4
`define BSS_OC_FAULT_PER 16
`define BSS_OC_QUIET_PER 3
`define BSS_LDO_DLY_US 100
`define BSS_LDO_RAMP_US 250

// ==========================================================
// Register offsets (byte addresses)
`define BSS_OFF_CTRL 12'h000
`define BSS_OFF_STATUS 12'h004
`define BSS_OFF_CLEAR 12'h008
`define BSS_OFF_IEN 12'h00C
`define BSS_OFF_STATE 12'h010

// ==========================================================
// Field layouts and reset values
`define BSS_CTRL_W 7
`define BSS_CTRL_RST 7'h00
`define BSS_ST_W 4
`define BSS_ST_OC 0
`define BSS_ST_OV 1
`define BSS_ST_UV 2
`define BSS_ST_LDO 3
`define BSS_IEN_RST 4'h0
`define BSS_OCC_W 5

// ==========================================================
// Gate-drive voltage codes
`define BSS_VSEL_7V 2'h3
`define BSS_VSEL_10V 2'h2
`define BSS_VSEL_12V 2'h0
`define BSS_VSEL_15V 2'h1

`endif

/* File: hdl/bss_pkg.sv */
/*
 * Types of the buck supply supervisor.
 * Assumes bss_params.svh for the figures.
 */
package bss_pkg;

    // ==========================================================
    // Bus, sense and control carriers
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } bss_apb_req_t;

    typedef struct packed {
        logic peak_oc;
        logic ontime_done;
        logic over_voltage;
        logic output_uv;
        logic supply_below_thr;
        logic supply_too_low;
        logic gain_load_done;
        logic lowside_uvlo;
    } bss_sense_t;

    typedef struct packed {
        logic [1:0] ldo_ocp_level;
        logic [1:0] ldo_softstart_time;
        logic [1:0] gate_drive_voltage_sel;
        logic converter_freq_sel;
    } bss_ctrl_t;

    // ==========================================================
    // States and codes
    typedef enum logic [1:0] {
        BSS_LDO_IDLE,
        BSS_LDO_DELAY,
        BSS_LDO_RAMP,
        BSS_LDO_ON
    } bss_ldo_state_t;

    typedef enum logic [1:0] {
        BSS_VT_6V5,
        BSS_VT_7V0,
        BSS_VT_8V0
    } bss_vtarget_t;

endpackage : bss_pkg

/* File: hdl/bss_supervisor.sv */
/*
 * Buck supply supervisor: switching period, high/low side drive, protection,
 * over-current fault counter, linear regulator start sequence, APB registers.
 * Assumes sense inputs synchronous to clk, single APB master.
 */
//
// Behaviour
// - The switching period is 500 kHz or 1 MHz as chosen by a control bit.
// - The output target code follows the gate-drive select (11:6.5V, 10:7V, 00/01:8V).
// - With input too low the on-time end is ignored and duty saturates at its maximum.
// - Output under-voltage flags a fault and holds the linear regulator off.
// - Over-voltage turns both switches off at once.
// - Peak current ends the high-side pulse until the next period; low side follows after dead time.
// - A low input supply selects the reduced over-current level.
// - Sixteen consecutive over-current periods raise the fault and pull the fault pin low.
// - Three quiet periods clear the consecutive counter without a fault.
// - Switching goes on in current limit after the fault.
// - The fault sets the converter over-current flag in the status register.
// - Gate-driver faults do not stop the converter or the regulator.
// - Regulator soft start begins a fixed delay after output good and gain load done.
// - The soft-start ramp length comes from a software field.
// - The regulator over-current level is software programmable.
`timescale 1ns/100ps
`include "bss_params.svh"

module bss_supervisor #(
    parameter int LDO_DLY_CYC = `BSS_LDO_DLY_US * `BSS_NS_PER_US / `BSS_CLK_NS,
    parameter int LDO_RAMP_CYC = `BSS_LDO_RAMP_US * `BSS_NS_PER_US / `BSS_CLK_NS
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // APB
    input bss_pkg::bss_apb_req_t apb_req,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // Analog sense
    input bss_pkg::bss_sense_t sense,
    // Converter drive
    output logic hs_gate,
    output logic ls_gate,
    output logic period_start,
    output logic limiter_active,
    output logic oc_level_reduced,
    output logic [1:0] target_code,
    // Linear regulator
    output logic ldo_enable,
    output logic ldo_ramping,
    output logic [1:0] ldo_ramp_sel,
    output logic [1:0] ldo_ocp_sel,
    // Fault reporting
    output logic fault_out_n,
    output logic irq
);

    // ==========================================================
    // Constants and functions
    localparam int PER_500K = `BSS_NS_PER_MS / (`BSS_F500_KHZ * `BSS_CLK_NS);
    localparam int PER_1M = `BSS_NS_PER_MS / (`BSS_F1M_KHZ * `BSS_CLK_NS);
    localparam int DEAD = `BSS_DEAD_CYC;

    function automatic logic [15:0] period_len(input logic f);
        period_len = f ? 16'(PER_1M) : 16'(PER_500K);
    endfunction : period_len

    function automatic logic [1:0] target_of(input logic [1:0] v);
        unique case (v)
            `BSS_VSEL_7V: target_of = bss_pkg::BSS_VT_6V5;
            `BSS_VSEL_10V: target_of = bss_pkg::BSS_VT_7V0;
            default: target_of = bss_pkg::BSS_VT_8V0;
        endcase
    endfunction : target_of

    function automatic logic addr_hit(input logic [11:0] a);
        addr_hit = (a == `BSS_OFF_CTRL) || (a == `BSS_OFF_STATUS) || (a == `BSS_OFF_CLEAR)
            || (a == `BSS_OFF_IEN) || (a == `BSS_OFF_STATE);
    endfunction : addr_hit

    // ==========================================================
    // Declarations
    bss_pkg::bss_ctrl_t ctrl;
    bss_pkg::bss_ldo_state_t ldo_state;
    bss_pkg::bss_ldo_state_t next_ldo_state;
    logic [`BSS_ST_W-1:0] status;
    logic [`BSS_ST_W-1:0] next_status;
    logic [`BSS_ST_W-1:0] ien;
    logic [`BSS_ST_W-1:0] clr;
    logic [15:0] period_cnt;
    logic [15:0] len;
    logic [15:0] duty_max;
    logic [15:0] off_cnt;
    logic wrap;
    logic oc_seen;
    logic per_oc;
    logic oc_fault_evt;
    logic [`BSS_OCC_W-1:0] oc_count;
    logic [1:0] quiet_cnt;
    logic [31:0] ldo_timer;
    logic [31:0] ramp_cyc;
    logic ldo_ready_evt;
    logic wr_en;
    logic [31:0] rd_mux;

    assign len = period_len(ctrl.converter_freq_sel);
    assign duty_max = 16'(32'(len) * `BSS_DUTY_MAX_PCT / `BSS_PCT_FULL);
    assign wrap = (period_cnt >= len - 16'd1);
    assign per_oc = oc_seen || sense.peak_oc;
    assign ramp_cyc = 32'(LDO_RAMP_CYC) << ctrl.ldo_softstart_time;
    assign ldo_ramp_sel = ctrl.ldo_softstart_time;
    assign ldo_ocp_sel = ctrl.ldo_ocp_level;

    // ==========================================================
    // Switching period
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            period_cnt <= '0;
            period_start <= 1'b0;
        end else begin
            period_cnt <= wrap ? 16'd0 : period_cnt + 16'd1;
            period_start <= wrap;
        end
    end

    // ==========================================================
    // Supply conditions
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            limiter_active <= 1'b0;
            oc_level_reduced <= 1'b0;
            target_code <= bss_pkg::BSS_VT_8V0;
        end else begin
            limiter_active <= sense.supply_too_low;
            oc_level_reduced <= sense.supply_below_thr;
            target_code <= target_of(ctrl.gate_drive_voltage_sel);
        end
    end

    // ==========================================================
    // High side drive; the low side rail fault is deliberately not a term
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            hs_gate <= 1'b0;
        end else if (sense.over_voltage) begin
            hs_gate <= 1'b0;
        end else if (wrap) begin
            hs_gate <= 1'b1;
        end else if (hs_gate && sense.peak_oc) begin
            hs_gate <= 1'b0;
        end else if (hs_gate && period_cnt >= duty_max - 16'd1) begin
            hs_gate <= 1'b0;
        end else if (hs_gate && !limiter_active && sense.ontime_done) begin
            hs_gate <= 1'b0;
        end
    end

    // ==========================================================
    // Low side drive after dead time, released before the next period
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            off_cnt <= '0;
            ls_gate <= 1'b0;
        end else begin
            off_cnt <= hs_gate ? 16'd0 : (off_cnt == 16'hFFFF ? off_cnt : off_cnt + 16'd1);
            ls_gate <= !sense.over_voltage && !hs_gate && (off_cnt >= 16'(DEAD - 1))
                && (period_cnt < len - 16'(DEAD + 1));
        end
    end

    // ==========================================================
    // Consecutive over-current period counter
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            oc_seen <= 1'b0;
            oc_count <= '0;
            quiet_cnt <= '0;
            oc_fault_evt <= 1'b0;
        end else begin
            oc_fault_evt <= 1'b0;
            if (wrap) begin
                oc_seen <= 1'b0;
                if (per_oc) begin
                    quiet_cnt <= '0;
                    if (oc_count < `BSS_OCC_W'(`BSS_OC_FAULT_PER)) begin
                        oc_count <= oc_count + 1'b1;
                    end
                    if (oc_count == `BSS_OCC_W'(`BSS_OC_FAULT_PER - 1)) begin
                        oc_fault_evt <= 1'b1;
                    end
                end else if (quiet_cnt == 2'(`BSS_OC_QUIET_PER - 1)) begin
                    quiet_cnt <= '0;
                    oc_count <= '0;
                end else begin
                    quiet_cnt <= quiet_cnt + 2'd1;
                end
            end else if (sense.peak_oc) begin
                oc_seen <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Linear regulator start sequence
    always_comb begin
        next_ldo_state = ldo_state;
        unique case (ldo_state)
            bss_pkg::BSS_LDO_IDLE: begin
                if (!sense.output_uv && sense.gain_load_done) begin
                    next_ldo_state = bss_pkg::BSS_LDO_DELAY;
                end
            end
            bss_pkg::BSS_LDO_DELAY: begin
                if (ldo_timer >= 32'(LDO_DLY_CYC - 1)) begin
                    next_ldo_state = bss_pkg::BSS_LDO_RAMP;
                end
            end
            bss_pkg::BSS_LDO_RAMP: begin
                if (ldo_timer >= ramp_cyc - 32'd1) begin
                    next_ldo_state = bss_pkg::BSS_LDO_ON;
                end
            end
            bss_pkg::BSS_LDO_ON: begin
            end
        endcase
        if (sense.output_uv) begin
            next_ldo_state = bss_pkg::BSS_LDO_IDLE;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ldo_state <= bss_pkg::BSS_LDO_IDLE;
            ldo_timer <= '0;
            ldo_enable <= 1'b0;
            ldo_ramping <= 1'b0;
            ldo_ready_evt <= 1'b0;
        end else begin
            ldo_state <= next_ldo_state;
            ldo_timer <= (next_ldo_state != ldo_state) ? 32'd0 : ldo_timer + 32'd1;
            ldo_enable <= (next_ldo_state == bss_pkg::BSS_LDO_RAMP)
                || (next_ldo_state == bss_pkg::BSS_LDO_ON);
            ldo_ramping <= (next_ldo_state == bss_pkg::BSS_LDO_RAMP);
            ldo_ready_evt <= (next_ldo_state == bss_pkg::BSS_LDO_ON)
                && (ldo_state == bss_pkg::BSS_LDO_RAMP);
        end
    end

    // ==========================================================
    // APB slave, one wait state
    assign wr_en = apb_req.psel && apb_req.penable && pready && apb_req.pwrite;
    assign clr = (wr_en && apb_req.paddr == `BSS_OFF_CLEAR) ? apb_req.pwdata[`BSS_ST_W-1:0] : '0;

    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (apb_req.paddr)
            `BSS_OFF_CTRL: rd_mux = 32'(ctrl);
            `BSS_OFF_STATUS: rd_mux = 32'(status);
            `BSS_OFF_IEN: rd_mux = 32'(ien);
            `BSS_OFF_STATE: rd_mux = {19'h0_0000, sense.lowside_uvlo, ldo_state, oc_count,
                limiter_active, ls_gate, hs_gate, target_code};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= 1'b0;
            if (apb_req.psel && apb_req.penable && !pready) begin
                pready <= 1'b1;
                prdata <= apb_req.pwrite ? 32'h0000_0000 : rd_mux;
                pslverr <= !addr_hit(apb_req.paddr);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctrl <= `BSS_CTRL_RST;
            ien <= `BSS_IEN_RST;
        end else begin
            if (wr_en && apb_req.paddr == `BSS_OFF_CTRL) begin
                ctrl <= apb_req.pwdata[`BSS_CTRL_W-1:0];
            end
            if (wr_en && apb_req.paddr == `BSS_OFF_IEN) begin
                ien <= apb_req.pwdata[`BSS_ST_W-1:0];
            end
        end
    end

    // ==========================================================
    // Sticky status, fault pin and interrupt; a set beats a clear
    always_comb begin
        next_status = status & ~clr;
        next_status[`BSS_ST_OC] = next_status[`BSS_ST_OC] | oc_fault_evt;
        next_status[`BSS_ST_OV] = next_status[`BSS_ST_OV] | sense.over_voltage;
        next_status[`BSS_ST_UV] = next_status[`BSS_ST_UV] | sense.output_uv;
        next_status[`BSS_ST_LDO] = next_status[`BSS_ST_LDO] | ldo_ready_evt;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            status <= '0;
            fault_out_n <= 1'b1;
            irq <= 1'b0;
        end else begin
            status <= next_status;
            fault_out_n <= !next_status[`BSS_ST_OC];
            irq <= |(status & ien);
        end
    end

    // ==========================================================
    // Assertions
    property p_freq;
        @(posedge clk) disable iff (sys_rst) period_cnt < len || $changed(len);
    endproperty
    a_freq: assert property (p_freq) else $error("period counter beyond period");

    property p_target;
        @(posedge clk) disable iff (sys_rst)
            1'b1 |=> target_code == target_of($past(ctrl.gate_drive_voltage_sel));
    endproperty
    a_target: assert property (p_target) else $error("target code mismatch");

    property p_limiter;
        @(posedge clk) disable iff (sys_rst)
            limiter_active && hs_gate && !wrap && period_cnt < duty_max - 16'd1
            && !sense.peak_oc && !sense.over_voltage |=> hs_gate;
    endproperty
    a_limiter: assert property (p_limiter) else $error("limiter pulse ended early");

    property p_uvlo;
        @(posedge clk) disable iff (sys_rst) sense.output_uv |=> !ldo_enable && status[`BSS_ST_UV];
    endproperty
    a_uvlo: assert property (p_uvlo) else $error("regulator on under output uv");

    property p_ovp;
        @(posedge clk) disable iff (sys_rst) sense.over_voltage |=> !hs_gate && !ls_gate;
    endproperty
    a_ovp: assert property (p_ovp) else $error("switch on under over voltage");

    property p_oc_cut;
        @(posedge clk) disable iff (sys_rst) hs_gate && sense.peak_oc && !wrap |=> !hs_gate;
    endproperty
    a_oc_cut: assert property (p_oc_cut) else $error("high side not cut");

    property p_dead;
        @(posedge clk) disable iff (sys_rst) $fell(hs_gate) |-> !ls_gate [*4];
    endproperty
    a_dead: assert property (p_dead) else $error("dead time violated");

    property p_reduce;
        @(posedge clk) disable iff (sys_rst) ##1 oc_level_reduced == $past(sense.supply_below_thr);
    endproperty
    a_reduce: assert property (p_reduce) else $error("reduced level not followed");

    property p_fault16;
        @(posedge clk) disable iff (sys_rst)
            wrap && per_oc && oc_count == `BSS_OCC_W'(`BSS_OC_FAULT_PER - 1) |=> ##1 !fault_out_n;
    endproperty
    a_fault16: assert property (p_fault16) else $error("fault not raised");

    property p_quiet;
        @(posedge clk) disable iff (sys_rst) wrap && !per_oc && quiet_cnt == 2'd2 |=> oc_count == '0;
    endproperty
    a_quiet: assert property (p_quiet) else $error("counter not cleared");

    property p_run;
        @(posedge clk) disable iff (sys_rst) wrap && !sense.over_voltage |=> hs_gate;
    endproperty
    a_run: assert property (p_run) else $error("period did not start");

    property p_hold;
        @(posedge clk) disable iff (sys_rst)
            status[`BSS_ST_OC] && clr[`BSS_ST_OC] == 1'b0 |=> status[`BSS_ST_OC] && !fault_out_n;
    endproperty
    a_hold: assert property (p_hold) else $error("flag dropped without clear");

    property p_start;
        @(posedge clk) disable iff (sys_rst) $rose(ldo_enable) |-> $past(ldo_state) == bss_pkg::BSS_LDO_DELAY;
    endproperty
    a_start: assert property (p_start) else $error("soft start without delay");

    c_fault: cover property (@(posedge clk) disable iff (sys_rst) $fell(fault_out_n));
    c_ldo_on: cover property (@(posedge clk) disable iff (sys_rst) $rose(ldo_ready_evt));
    c_limit: cover property (@(posedge clk) disable iff (sys_rst) limiter_active && $fell(hs_gate));
    c_irq: cover property (@(posedge clk) disable iff (sys_rst) $rose(irq));

endmodule : bss_supervisor

/* File: verification/bss_sense_model.sv */
/*
 * Far-side model: the power stage comparators and supply monitors.
 * Assumes the bench sets the conditions and the supervisor drives hs_gate.
 */
`timescale 1ns/100ps
module bss_sense_model #(
    parameter int OC_AT = 20,
    parameter int ON_CYC = 60
) (
    // Clock and drive
    input wire logic clk,
    input wire logic hs_gate,
    // Conditions: oc, ov, uv, below, too_low, gain_done, ls_uvlo
    input wire logic [6:0] cond,
    // Sense lines
    output bss_pkg::bss_sense_t sense
);
    int hi_cnt;

    // ==========================================================
    // On-time seen by the current sensor
    always_ff @(posedge clk) begin
        hi_cnt <= hs_gate ? hi_cnt + 1 : 0;
    end

    always_comb begin
        sense.peak_oc = cond[6] && hs_gate && hi_cnt >= OC_AT;
        sense.ontime_done = hs_gate && hi_cnt >= ON_CYC;
        sense.over_voltage = cond[5];
        sense.output_uv = cond[4];
        sense.supply_below_thr = cond[3];
        sense.supply_too_low = cond[2];
        sense.gain_load_done = cond[1];
        sense.lowside_uvlo = cond[0];
    end
endmodule : bss_sense_model

/* File: verification/bss_supervisor_tb_top.sv */
/*
 * Self-checking bench of the buck supply supervisor.
 * Assumes bss_params.svh and bss_pkg are compiled first.
 */
`timescale 1ns/100ps
`include "bss_params.svh"
module bss_supervisor_tb_top;
    // ==========================================================
    // Signals
    logic clk, sys_rst, oc_on, ov, uv, below, too_low, gain_done, ls_uvlo, er;
    bss_pkg::bss_apb_req_t apb_req;
    bss_pkg::bss_sense_t sense;
    logic pready, pslverr, hs_gate, ls_gate, period_start, limiter_active, oc_level_reduced;
    logic ldo_enable, ldo_ramping, fault_out_n, irq;
    logic [1:0] target_code, ldo_ramp_sel, ldo_ocp_sel, sel, ocp;
    logic [31:0] prdata, rd;
    int err_count, n_compared, seed, len, hi, lo, n, m;
    int vt_model[4] = '{2, 2, 1, 0};

    bss_supervisor #(.LDO_DLY_CYC(10), .LDO_RAMP_CYC(8)) u_dut (.clk(clk), .sys_rst(sys_rst),
        .apb_req(apb_req), .pready(pready), .prdata(prdata), .pslverr(pslverr), .sense(sense),
        .hs_gate(hs_gate), .ls_gate(ls_gate), .period_start(period_start), .limiter_active(limiter_active),
        .oc_level_reduced(oc_level_reduced), .target_code(target_code), .ldo_enable(ldo_enable),
        .ldo_ramping(ldo_ramping), .ldo_ramp_sel(ldo_ramp_sel), .ldo_ocp_sel(ldo_ocp_sel),
        .fault_out_n(fault_out_n), .irq(irq));

    bss_sense_model u_far (.clk(clk), .hs_gate(hs_gate),
        .cond({oc_on, ov, uv, below, too_low, gain_done, ls_uvlo}), .sense(sense));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // ==========================================================
    // Tasks
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int w;
        @(posedge clk);
        apb_req <= '{1'b1, 1'b0, wr, a, d};
        @(posedge clk);
        apb_req.penable <= 1'b1;
        w = 0;
        do begin
            @(posedge clk);
            w++;
        end while (pready !== 1'b1 && w < 20);
        rd = prdata;
        er = pslverr;
        if (w >= 20) err_count++;
        apb_req <= '0;
    endtask : apb

    task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        check(what, rd, e);
    endtask : rdchk

    task automatic tick(input int k);
        repeat (k) @(negedge clk);
    endtask : tick

    task automatic wait_period();
        int w;
        w = 0;
        do begin
            @(negedge clk);
            w++;
        end while (period_start !== 1'b1 && w < 1000);
    endtask : wait_period

    // Length of one whole period and its high-side on-time
    task automatic measure();
        wait_period();
        len = 0;
        hi = 0;
        lo = 0;
        do begin
            if (hs_gate === 1'b1) hi++;
            if (ls_gate === 1'b1) lo++;
            len++;
            @(negedge clk);
        end while (period_start !== 1'b1 && len < 1000);
    endtask : measure

    // Over-current in exactly cnt whole periods
    task automatic oc_run(input int cnt, input logic on);
        wait_period();
        @(posedge clk) oc_on <= on;
        repeat (cnt) wait_period();
        @(posedge clk) oc_on <= 1'b0;
    endtask : oc_run

    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : complete_run

    initial begin
        repeat (100000) @(posedge clk);
        err_count++;
        complete_run();
    end

    // ==========================================================
    // Scenarios
    initial begin
        seed = 82155;
        err_count = 0;
        n_compared = 0;
        sys_rst = 1'b1;
        apb_req = '0;
        {oc_on, ov, uv, below, too_low, gain_done, ls_uvlo} = 7'h00;
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        tick(2);
        check("fault_rst", fault_out_n, 1);
        check("target_rst", target_code, 2);
        rdchk("ctrl_rst", `BSS_OFF_CTRL, 32'h0000_0000);
        rdchk("ien_rst", `BSS_OFF_IEN, 32'h0000_0000);
        rdchk("status_rst", `BSS_OFF_STATUS, 32'h0000_0000);
        apb(1'b0, 12'h020, 32'h0000_0000);
        check("unmapped", {rd[30:0], er}, 1);
        measure();
        check("period_500k", len, 400);
        sel = 2'($random(seed));
        ocp = 2'($random(seed));
        // Frequency is part of the one-off configuration
        for (int k = 0; k < 4; k++) begin
            apb(1'b1, `BSS_OFF_CTRL, {25'h000_0000, ocp, sel, 2'(k), 1'b1});
            tick(2);
            check("target", target_code, vt_model[k]);
        end
        check("ramp_sel", ldo_ramp_sel, sel);
        check("ocp_sel", ldo_ocp_sel, ocp);
        measure();
        check("period_1m", len, 200);
        check("ontime_short", hi < 180, 1);
        @(posedge clk) too_low <= 1'b1;
        measure();
        check("limiter", limiter_active, 1);
        check("limiter_duty", hi, 180);
        // Low side: 20 off cycles less 4 dead cycles less 4 before the period end
        check("limiter_low", lo, 12);
        @(posedge clk) too_low <= 1'b0;
        @(posedge clk) below <= 1'b1;
        tick(2);
        check("oc_reduced", oc_level_reduced, 1);
        @(posedge clk) below <= 1'b0;
        tick(2);
        check("oc_normal", oc_level_reduced, 0);
        apb(1'b1, `BSS_OFF_IEN, 32'h0000_0001);
        oc_run(15, 1'b1);
        tick(4);
        check("fault_15", fault_out_n, 1);
        oc_run(1, 1'b0);
        oc_run(15, 1'b1);
        tick(4);
        check("fault_quiet", fault_out_n, 1);
        oc_run(1, 1'b0);
        oc_run(16, 1'b1);
        tick(4);
        check("fault_16", fault_out_n, 0);
        check("irq_on", irq, 1);
        @(posedge clk) oc_on <= 1'b1;
        measure();
        check("limit_period", len, 200);
        check("limit_pulse", hi > 0 && hi < 30, 1);
        @(posedge clk) oc_on <= 1'b0;
        measure();
        check("fault_hold", fault_out_n, 0);
        rdchk("status_oc", `BSS_OFF_STATUS, 32'h0000_0001);
        apb(1'b1, `BSS_OFF_IEN, 32'h0000_0000);
        tick(2);
        check("irq_mask", irq, 0);
        apb(1'b1, `BSS_OFF_IEN, 32'h0000_0001);
        tick(2);
        check("irq_unmask", irq, 1);
        apb(1'b1, `BSS_OFF_CLEAR, 32'h0000_0001);
        tick(2);
        check("fault_clr", {irq, fault_out_n}, 1);
        @(posedge clk) ov <= 1'b1;
        tick(2);
        n = 0;
        repeat (250) begin
            @(negedge clk);
            if ((hs_gate | ls_gate) !== 1'b0) n++;
        end
        check("ovp_off", n, 0);
        @(posedge clk) ov <= 1'b0;
        @(posedge clk);
        ls_uvlo <= 1'b1;
        gain_done <= 1'b1;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (ldo_enable !== 1'b1 && n < 100);
        check("ldo_delay", n >= 10 && n <= 13, 1);
        m = 0;
        while (ldo_ramping === 1'b1 && m < 2000) begin
            @(negedge clk);
            m++;
        end
        check("ldo_ramp", m, 8 << sel);
        measure();
        check("uvlo_period", {ldo_enable, len[30:0]}, {1'b1, 31'd200});
        rdchk("status_ldo", `BSS_OFF_STATUS, 32'h0000_000A);
        @(posedge clk);
        uv <= 1'b1;
        gain_done <= 1'b0;
        tick(2);
        check("uv_ldo_off", ldo_enable, 0);
        @(posedge clk) uv <= 1'b0;
        rdchk("status_uv", `BSS_OFF_STATUS, 32'h0000_000E);
        apb(1'b1, `BSS_OFF_STATUS, 32'h0000_0000);
        rdchk("status_ro", `BSS_OFF_STATUS, 32'h0000_000E);
        apb(1'b1, `BSS_OFF_CLEAR, 32'h0000_000F);
        rdchk("status_clr", `BSS_OFF_STATUS, 32'h0000_0000);
        complete_run();
    end
endmodule : bss_supervisor_tb_top
